// [shared/apc_pkg.sv]
package apc_pkg;
   // Register byte offsets on the AXI4-Lite slave
   localparam logic [7:0] OFS_REF2_SET = 8'h00;
   localparam logic [7:0] OFS_PE_ONE = 8'h04;
   localparam logic [7:0] OFS_ROLE = 8'h08;
   localparam logic [7:0] OFS_DEADTIME = 8'h0c;
   localparam logic [7:0] OFS_ABE = 8'h10;
   localparam logic [7:0] OFS_TMR2_PER = 8'h14;
   localparam logic [7:0] OFS_TMR1_LOW = 8'h18;
   localparam logic [7:0] OFS_DESATURATION_COMPARATOR_CTL = 8'h1c;
   localparam logic [7:0] OFS_STATUS = 8'h20;

   // Reset values
   localparam logic [7:0] RST_REF2_SET = 8'h00;
   localparam logic [7:0] RST_PE_ONE = 8'h04;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_DESATURATION_COMPARATOR_CTL = 8'h01;

   // Peripheral-enable bits
   localparam int PE_PRI_DRV_EN = 7;
   localparam int PE_SEC_DRV_EN = 6;
   localparam int PE_PRI_DT_BYP = 5;
   localparam int PE_SEC_DT_BYP = 4;
   localparam int PE_PULLUP_EN = 2;
   localparam int PE_PRI_STEER = 1;
   localparam int PE_SEC_STEER = 0;
   localparam logic [7:0] PE_WRITE_MASK = 8'hf7;

   // Analog block enable bits
   localparam int ABE_DIG_OE = 7;
   localparam int ABE_DSEL_HI = 6;
   localparam int ABE_DSEL_LO = 4;
   localparam int ABE_ANA_OE = 0;

   // Dead time fields and timing
   localparam int DT_PRI_HI = 7;
   localparam int DT_PRI_LO = 4;
   localparam int DT_SEC_HI = 3;
   localparam int DT_SEC_LO = 0;
   localparam int DT_STEP_NS = 16;
   localparam int CLK_PERIOD_NS = 50;

   // System role
   localparam logic [1:0] ROLE_MASTER = 2'h1;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Digital test channels
   typedef enum logic [2:0] {
      APC_DT_DESATURATION_COMPARATOR, APC_DT_PWM_MONO, APC_DT_OSC_PWM, APC_DT_TMR2_MATCH,
      APC_DT_OV_CMP, APC_DT_SW_FREQ, APC_DT_SEC_ONESHOT, APC_DT_UNUSED
   } apc_dsel_t;
endpackage

// [core/apc_deadtime.sv]
`timescale 1ns/1ns
`default_nettype none
// Delays the rising edge of a gate drive by the programmed dead time
module apc_deadtime #(
   parameter int CODE_W = 4
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic resetn_in,
   // Drive path
   input wire logic drive_in,
   input wire logic [CODE_W-1:0] code_in,
   input wire logic bypass_in,
   output logic drive_out
);
   logic [7:0] cnt_r;
   logic [7:0] need;
   int dt_ns;

   // Least time rounds up to whole cycles
   assign dt_ns = (int'(code_in) + 1) * apc_pkg::DT_STEP_NS;
   assign need = 8'((dt_ns + apc_pkg::CLK_PERIOD_NS - 1) / apc_pkg::CLK_PERIOD_NS);

   always_ff @(posedge mclk_in) begin
      if (!resetn_in || !drive_in) begin
         cnt_r <= 8'h00;
      end else if (cnt_r < need) begin
         cnt_r <= cnt_r + 8'h01;
      end
   end

   assign drive_out = drive_in & (bypass_in | (cnt_r >= need));
endmodule
`default_nettype wire

// [core/apc_steer_pwm.sv]
`timescale 1ns/1ns
`default_nettype none
// Fixed open-loop PWM: period from the timer-2 period, duty from timer-1 low byte
module apc_steer_pwm #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic resetn_in,
   // Setting
   input wire logic [W-1:0] period_in,
   input wire logic [W-1:0] duty_in,
   output logic pwm_out
);
   logic [W-1:0] cnt_r;

   always_ff @(posedge mclk_in) begin
      if (!resetn_in || cnt_r >= period_in) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + W'(1);
      end
   end

   assign pwm_out = cnt_r < duty_in;
endmodule
`default_nettype wire

// [core/apc_top.sv]
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// RQ1: Reference output reaches its pin only when role select is master (01).
// RQ2: Holds an 8-bit reference code, no pedestal, linear over 255 steps.
// RQ3: Primary gate drive enabled only while enable bit 7 is one.
// RQ4: Secondary gate drive enabled only while enable bit 6 is one.
// RQ5: Bit 5 set bypasses dead time on the primary path.
// RQ6: Bit 4 set bypasses dead time on the secondary path.
// RQ7: Bit 3 is unimplemented, reads zero, writes ignored.
// RQ8: Bit 2, reset one, enables the weak sense-pin pull-up.
// RQ9: Bit 1 steers open-loop PWM onto the primary drive only.
// RQ10: Bit 0 steers PWM to secondary, only while overvoltage protection active.
// RQ11: Both steering bits set: primary steering wins, secondary suppressed.
// RQ12: Steering frequency from timer-2 period, duty from timer-1 low byte.
// RQ13: Dead time per driver 16 ns to 256 ns in 16 ns steps; here rounded up to whole 50 ns clock cycles, 50 ns to 300 ns.
// RQ14: Software should clear desaturation_comparator output enable for quasi-resonant steering.
// RQ15: Digital test enable puts the selected digital channel on the debug pin.
// RQ16: Analog test enable connects analog signal to the pin; digital wins.
// RQ17: Analog enable clear routes analog test signals to the converter.
// RQ18: Channel decode 000..110 as listed; 111 unused.
// RQ19: A disabled driver output is held low whatever PWM is active.
module apc_top #(
   parameter int AW = 8
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic resetn_in,
   // AXI4-Lite write address
   input wire logic [AW-1:0] awaddr_in,
   input wire logic awvalid_in,
   output logic awready_out,
   // AXI4-Lite write data
   input wire logic [31:0] wdata_in,
   input wire logic [3:0] wstrb_in,
   input wire logic wvalid_in,
   output logic wready_out,
   // AXI4-Lite write response
   output logic [1:0] bresp_out,
   output logic bvalid_out,
   input wire logic bready_in,
   // AXI4-Lite read
   input wire logic [AW-1:0] araddr_in,
   input wire logic arvalid_in,
   output logic arready_out,
   output logic [31:0] rdata_out,
   output logic [1:0] rresp_out,
   output logic rvalid_out,
   input wire logic rready_in,
   // Closed-loop PWM and protection
   input wire logic loop_primary_pwm_in,
   input wire logic loop_secondary_pwm_in,
   input wire logic ovp_active_in,
   // Digital test sources
   input wire logic desaturation_comparator_in,
   input wire logic pwm_post_mono_in,
   input wire logic osc_pwm_in,
   input wire logic tmr2_match_in,
   input wire logic ov_comparator_in,
   input wire logic sw_freq_in,
   input wire logic sec_oneshot_in,
   // Gate drives
   output logic primary_gate_output_out,
   output logic secondary_gate_output_out,
   // Analog controls
   output logic [7:0] second_reference_code_out,
   output logic reference_output_pin_connect_out,
   output logic sense_pin_pullup_enable_out,
   output logic desaturation_comparator_output_enable_out,
   // Debug pin
   output logic debug_output_pin_out,
   output logic debug_output_pin_oe_out,
   output logic debug_analog_connect_out,
   output logic analog_to_converter_out
);
   ////////////////////////////////////////////////////////////////////////////
   // Register state
   logic [7:0] ref2_r;
   logic [7:0] pe_r;
   logic [1:0] role_r;
   logic [7:0] dt_r;
   logic [7:0] abe_r;
   logic [7:0] tmr2_per_r;
   logic [7:0] tmr1_low_r;
   logic desaturation_comparator_oe_r;

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel
   logic aw_hold_r;
   logic w_hold_r;
   logic [AW-1:0] waddr_r;
   logic [7:0] wbyte_r;
   logic wlane_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic aw_take;
   logic w_take;
   logic do_write;
   logic wr_en;
   logic wr_hit;
   logic aw_hold_nxt;
   logic w_hold_nxt;

   // Ready is still low at the first edge out of reset, so a take must see it high
   assign aw_take = awvalid_in & awready_out & ~aw_hold_r;
   assign w_take = wvalid_in & wready_out & ~w_hold_r;
   assign do_write = aw_hold_r & w_hold_r & ~bvalid_r;
   assign aw_hold_nxt = aw_take | (aw_hold_r & ~do_write);
   assign w_hold_nxt = w_take | (w_hold_r & ~do_write);
   assign wr_en = do_write & wlane_r;
   assign wr_hit = waddr_r == AW'(apc_pkg::OFS_REF2_SET)
      || waddr_r == AW'(apc_pkg::OFS_PE_ONE)
      || waddr_r == AW'(apc_pkg::OFS_ROLE)
      || waddr_r == AW'(apc_pkg::OFS_DEADTIME)
      || waddr_r == AW'(apc_pkg::OFS_ABE)
      || waddr_r == AW'(apc_pkg::OFS_TMR2_PER)
      || waddr_r == AW'(apc_pkg::OFS_TMR1_LOW)
      || waddr_r == AW'(apc_pkg::OFS_DESATURATION_COMPARATOR_CTL)
      || waddr_r == AW'(apc_pkg::OFS_STATUS);

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awready_out <= 1'b0;
         wready_out <= 1'b0;
         waddr_r <= '0;
         wbyte_r <= 8'h00;
         wlane_r <= 1'b0;
      end else begin
         aw_hold_r <= aw_hold_nxt;
         w_hold_r <= w_hold_nxt;
         awready_out <= ~aw_hold_nxt;
         wready_out <= ~w_hold_nxt;
         if (aw_take && awready_out) begin
            waddr_r <= awaddr_in;
         end
         if (w_take && wready_out) begin
            wbyte_r <= wdata_in[7:0];
            wlane_r <= wstrb_in[0];
         end
      end
   end

   // Hold flags follow the registered ready, so a take only counts when ready was high
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         bvalid_r <= 1'b0;
         bresp_r <= apc_pkg::RESP_OKAY;
      end else if (do_write) begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_hit ? apc_pkg::RESP_OKAY : apc_pkg::RESP_SLVERR;
      end else if (bready_in) begin
         bvalid_r <= 1'b0;
      end
   end

   assign bvalid_out = bvalid_r;
   assign bresp_out = bresp_r;

   ////////////////////////////////////////////////////////////////////////////
   // Register writes
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         ref2_r <= apc_pkg::RST_REF2_SET;
         pe_r <= apc_pkg::RST_PE_ONE; // [RQ8]
         role_r <= 2'h0;
         dt_r <= apc_pkg::RST_ZERO;
         abe_r <= apc_pkg::RST_ZERO;
         tmr2_per_r <= apc_pkg::RST_ZERO;
         tmr1_low_r <= apc_pkg::RST_ZERO;
         desaturation_comparator_oe_r <= apc_pkg::RST_DESATURATION_COMPARATOR_CTL[0];
      end else if (wr_en) begin
         case (waddr_r)
            AW'(apc_pkg::OFS_REF2_SET): ref2_r <= wbyte_r; // [RQ2]
            AW'(apc_pkg::OFS_PE_ONE): pe_r <= wbyte_r & apc_pkg::PE_WRITE_MASK; // [RQ7]
            AW'(apc_pkg::OFS_ROLE): role_r <= wbyte_r[1:0];
            AW'(apc_pkg::OFS_DEADTIME): dt_r <= wbyte_r; // [RQ13]
            AW'(apc_pkg::OFS_ABE): abe_r <= wbyte_r;
            AW'(apc_pkg::OFS_TMR2_PER): tmr2_per_r <= wbyte_r;
            AW'(apc_pkg::OFS_TMR1_LOW): tmr1_low_r <= wbyte_r;
            AW'(apc_pkg::OFS_DESATURATION_COMPARATOR_CTL): desaturation_comparator_oe_r <= wbyte_r[0]; // [RQ14]
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel
   logic rvalid_r;
   logic ar_take;
   logic rvalid_nxt;
   logic [7:0] status;
   logic [7:0] rd_byte;
   logic rd_hit;

   assign ar_take = arvalid_in & arready_out;
   assign rvalid_nxt = ar_take | (rvalid_r & ~rready_in);
   assign status = {2'h0, analog_to_converter_out, debug_analog_connect_out,
      debug_output_pin_oe_out, reference_output_pin_connect_out,
      primary_gate_output_out, secondary_gate_output_out};

   always_comb begin
      rd_byte = 8'h00;
      rd_hit = 1'b1;
      case (araddr_in)
         AW'(apc_pkg::OFS_REF2_SET): rd_byte = ref2_r;
         AW'(apc_pkg::OFS_PE_ONE): rd_byte = pe_r;
         AW'(apc_pkg::OFS_ROLE): rd_byte = {6'h00, role_r};
         AW'(apc_pkg::OFS_DEADTIME): rd_byte = dt_r;
         AW'(apc_pkg::OFS_ABE): rd_byte = abe_r;
         AW'(apc_pkg::OFS_TMR2_PER): rd_byte = tmr2_per_r;
         AW'(apc_pkg::OFS_TMR1_LOW): rd_byte = tmr1_low_r;
         AW'(apc_pkg::OFS_DESATURATION_COMPARATOR_CTL): rd_byte = {7'h00, desaturation_comparator_oe_r};
         AW'(apc_pkg::OFS_STATUS): rd_byte = status;
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         rvalid_r <= 1'b0;
         arready_out <= 1'b0;
         rdata_out <= 32'h0000_0000;
         rresp_out <= apc_pkg::RESP_OKAY;
      end else begin
         rvalid_r <= rvalid_nxt;
         arready_out <= ~rvalid_nxt;
         if (ar_take) begin
            rdata_out <= {24'h00_0000, rd_byte};
            rresp_out <= rd_hit ? apc_pkg::RESP_OKAY : apc_pkg::RESP_SLVERR;
         end
      end
   end

   assign rvalid_out = rvalid_r;

   ////////////////////////////////////////////////////////////////////////////
   // Steering and drive paths
   logic steer_pwm;
   logic pri_steer;
   logic sec_steer;
   logic pri_src;
   logic sec_src;
   logic pri_dt;
   logic sec_dt;

   apc_steer_pwm #(.W(8)) u_steer (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .period_in(tmr2_per_r), // [RQ12]
      .duty_in(tmr1_low_r),
      .pwm_out(steer_pwm)
   );

   assign pri_steer = pe_r[apc_pkg::PE_PRI_STEER]; // [RQ9]
   // Primary steering dominates a conflicting secondary request
   assign sec_steer = pe_r[apc_pkg::PE_SEC_STEER] & ~pri_steer; // [RQ11]
   // Steering drives one side only; the other is parked low
   assign pri_src = pri_steer ? steer_pwm : (~sec_steer & loop_primary_pwm_in);
   assign sec_src = sec_steer ? (steer_pwm & ovp_active_in) // [RQ10]
      : (~pri_steer & loop_secondary_pwm_in);

   apc_deadtime #(.CODE_W(4)) u_dt_pri (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .drive_in(pri_src),
      .code_in(dt_r[apc_pkg::DT_PRI_HI:apc_pkg::DT_PRI_LO]), // [RQ13]
      .bypass_in(pe_r[apc_pkg::PE_PRI_DT_BYP]), // [RQ5]
      .drive_out(pri_dt)
   );

   apc_deadtime #(.CODE_W(4)) u_dt_sec (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .drive_in(sec_src),
      .code_in(dt_r[apc_pkg::DT_SEC_HI:apc_pkg::DT_SEC_LO]),
      .bypass_in(pe_r[apc_pkg::PE_SEC_DT_BYP]), // [RQ6]
      .drive_out(sec_dt)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Test mux
   logic dig_sel;
   logic dig_oe;
   logic ana_oe;
   apc_pkg::apc_dsel_t dsel;

   assign dsel = apc_pkg::apc_dsel_t'(abe_r[apc_pkg::ABE_DSEL_HI:apc_pkg::ABE_DSEL_LO]);
   assign dig_oe = abe_r[apc_pkg::ABE_DIG_OE];
   assign ana_oe = abe_r[apc_pkg::ABE_ANA_OE];

   always_comb begin
      case (dsel) // [RQ18]
         apc_pkg::APC_DT_DESATURATION_COMPARATOR: dig_sel = desaturation_comparator_in;
         apc_pkg::APC_DT_PWM_MONO: dig_sel = pwm_post_mono_in;
         apc_pkg::APC_DT_OSC_PWM: dig_sel = osc_pwm_in;
         apc_pkg::APC_DT_TMR2_MATCH: dig_sel = tmr2_match_in;
         apc_pkg::APC_DT_OV_CMP: dig_sel = ov_comparator_in;
         apc_pkg::APC_DT_SW_FREQ: dig_sel = sw_freq_in;
         apc_pkg::APC_DT_SEC_ONESHOT: dig_sel = sec_oneshot_in;
         default: dig_sel = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output registers
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         primary_gate_output_out <= 1'b0;
         secondary_gate_output_out <= 1'b0;
         second_reference_code_out <= apc_pkg::RST_REF2_SET;
         reference_output_pin_connect_out <= 1'b0;
         sense_pin_pullup_enable_out <= apc_pkg::RST_PE_ONE[apc_pkg::PE_PULLUP_EN];
         desaturation_comparator_output_enable_out <= apc_pkg::RST_DESATURATION_COMPARATOR_CTL[0];
         debug_output_pin_out <= 1'b0;
         debug_output_pin_oe_out <= 1'b0;
         debug_analog_connect_out <= 1'b0;
         analog_to_converter_out <= 1'b1;
      end else begin
         // Enable gating sits after dead time so a disabled driver never pulses
         primary_gate_output_out <= pe_r[apc_pkg::PE_PRI_DRV_EN] & pri_dt; // [RQ3] [RQ19]
         secondary_gate_output_out <= pe_r[apc_pkg::PE_SEC_DRV_EN] & sec_dt; // [RQ4] [RQ19]
         second_reference_code_out <= ref2_r; // [RQ2]
         reference_output_pin_connect_out <= role_r == apc_pkg::ROLE_MASTER; // [RQ1]
         sense_pin_pullup_enable_out <= pe_r[apc_pkg::PE_PULLUP_EN]; // [RQ8]
         desaturation_comparator_output_enable_out <= desaturation_comparator_oe_r;
         debug_output_pin_out <= dig_oe & dig_sel; // [RQ15]
         debug_output_pin_oe_out <= dig_oe;
         debug_analog_connect_out <= ana_oe & ~dig_oe; // [RQ16]
         analog_to_converter_out <= ~ana_oe; // [RQ17]
      end
   end
endmodule
`default_nettype wire

// [bench/apc_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module apc_checker #(
   parameter int AW = 8
) (
   // Clock, reset and write path
   input wire logic mclk_in, resetn_in, awvalid_in, awready_out, wvalid_in, wready_out,
   input wire logic [AW-1:0] awaddr_in,
   input wire logic [31:0] wdata_in,
   input wire logic [3:0] wstrb_in,
   input wire logic [1:0] bresp_out,
   input wire logic bvalid_out,
   // Watched outputs
   input wire logic primary_gate_output_out, secondary_gate_output_out,
   input wire logic [7:0] second_reference_code_out,
   input wire logic reference_output_pin_connect_out, sense_pin_pullup_enable_out,
   input wire logic debug_output_pin_oe_out, debug_analog_connect_out, analog_to_converter_out
);
   // Shadow of written registers by word index; lags the design by one cycle
   logic [7:0] sh_r [0:4];
   logic [3:0] a_r;
   logic [7:0] d_r;
   logic s_r, bv_r;
   wire ok_w = bresp_out == apc_pkg::RESP_OKAY;
   wire wr_w = bvalid_out && !bv_r && s_r && ok_w && a_r < 4'h5;
   // Outputs are judged only once the shadow has caught up
   wire q_w = !bvalid_out && !bv_r;
   always_ff @(posedge mclk_in) begin
      bv_r <= resetn_in && bvalid_out;
      if (awvalid_in && awready_out) a_r <= awaddr_in[5:2];
      if (wvalid_in && wready_out) d_r <= wdata_in[7:0];
      if (wvalid_in && wready_out) s_r <= wstrb_in[0];
      if (!resetn_in) sh_r <= '{8'h00, 8'h04, 8'h00, 8'h00, 8'h00};
      else if (wr_w) sh_r[a_r[2:0]] <= (a_r == 4'h1) ? d_r & apc_pkg::PE_WRITE_MASK : d_r;
   end
   ////////////////////////////////////////
   default clocking @(posedge mclk_in);
   endclocking
   default disable iff (!resetn_in);
   ref_code_a: assert property (q_w |-> second_reference_code_out == sh_r[0])
      else $error("reference code differs");
   ref_pin_a: assert property (q_w |-> reference_output_pin_connect_out ==
      (sh_r[2][1:0] == apc_pkg::ROLE_MASTER)) else $error("reference pin wrong");
   pri_gate_off_a: assert property (!sh_r[1][7] && $stable(sh_r[1])
      |-> !primary_gate_output_out) else $error("primary gate on while disabled");
   sec_gate_off_a: assert property (!sh_r[1][6] [*2]
      |-> !secondary_gate_output_out) else $error("secondary gate on while disabled");
   pullup_enable_a: assert property (q_w |-> sense_pin_pullup_enable_out == sh_r[1][2])
      else $error("pull-up enable wrong");
   pri_steer_a: assert property (q_w && sh_r[1][1] |-> !secondary_gate_output_out)
      else $error("secondary on during primary steering");
   dig_oe_a: assert property (q_w |-> debug_output_pin_oe_out == sh_r[4][7])
      else $error("debug enable wrong");
   ana_pin_a: assert property (q_w |-> debug_analog_connect_out ==
      (sh_r[4][0] && !sh_r[4][7])) else $error("analog pin connect wrong");
   ana_conv_a: assert property (q_w |-> analog_to_converter_out == !sh_r[4][0])
      else $error("converter routing wrong");
endmodule
bind apc_top apc_checker #(.AW(AW)) u_chk (.*);
`default_nettype wire

// [bench/apc_gate_model.sv]
`timescale 1ns/1ns
`default_nettype none
// Gate stage load: counts cycles each switch is driven on
module apc_gate_model (
   // Clock and count clear
   input wire logic mclk_in,
   input wire logic clear_in,
   // Gate drives
   input wire logic pri_gate_in,
   input wire logic sec_gate_in,
   // On-time counts
   output logic [15:0] pri_on_out,
   output logic [15:0] sec_on_out
);
   always_ff @(posedge mclk_in) begin
      if (clear_in) begin
         pri_on_out <= 16'h0000;
         sec_on_out <= 16'h0000;
      end else begin
         pri_on_out <= pri_on_out + 16'(pri_gate_in);
         sec_on_out <= sec_on_out + 16'(sec_gate_in);
      end
   end
endmodule
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   localparam logic [1:0] ok = apc_pkg::RESP_OKAY;
   logic mclk_in = 1'h0, resetn_in = 1'h0, clr = 1'h1;
   logic [7:0] awaddr_in = 8'h00, araddr_in = 8'h00;
   logic [31:0] wdata_in = 32'h0;
   logic [3:0] wstrb_in = 4'hf;
   logic awvalid_in = 1'h0, wvalid_in = 1'h0, bready_in = 1'h0;
   logic arvalid_in = 1'h0, rready_in = 1'h0, ovp_active_in = 1'h0;
   logic loop_primary_pwm_in = 1'h0, loop_secondary_pwm_in = 1'h0;
   logic desaturation_comparator_in, pwm_post_mono_in, osc_pwm_in, tmr2_match_in;
   logic ov_comparator_in, sw_freq_in, sec_oneshot_in;
   logic [6:0] src = 7'h00;
   logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
   logic [1:0] bresp_out, rresp_out;
   logic [31:0] rdata_out;
   logic primary_gate_output_out, secondary_gate_output_out, desaturation_comparator_output_enable_out;
   logic [7:0] second_reference_code_out;
   logic reference_output_pin_connect_out, sense_pin_pullup_enable_out;
   logic debug_output_pin_out, debug_output_pin_oe_out, debug_analog_connect_out;
   logic analog_to_converter_out;
   logic [15:0] pri_on, sec_on;
   logic [3:0] dt [3] = '{4'h0, 4'h3, 4'hf};
   // Steering cases: enables, overvoltage, expected primary and secondary on-time
   logic [31:0] st [4] = '{32'hf2011e00, 32'hf1000000, 32'hf101001e, 32'hf3011e00};
   int mismatches = 0, tests_run = 0, cyc = 0, d0, d1, p1, s1, k;
   assign {sec_oneshot_in, sw_freq_in, ov_comparator_in, tmr2_match_in} = src[6:3];
   assign {osc_pwm_in, pwm_post_mono_in, desaturation_comparator_in} = src[2:0];
   apc_top dut (.*);
   apc_gate_model pm (.mclk_in(mclk_in), .clear_in(clr), .pri_gate_in(primary_gate_output_out),
      .sec_gate_in(secondary_gate_output_out), .pri_on_out(pri_on), .sec_on_out(sec_on));
   always #25 mclk_in = ~mclk_in;
   ////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         print_verdict();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
      @(posedge mclk_in);
      awaddr_in <= a;
      wdata_in <= {24'h000000, d};
      awvalid_in <= 1'h1;
      wvalid_in <= 1'h1;
      bready_in <= 1'h1;
      do begin
         @(posedge mclk_in);
         if (awready_out) awvalid_in <= 1'h0;
         if (wready_out) wvalid_in <= 1'h0;
      end while (!bvalid_out);
      bready_in <= 1'h0;
      chk("bresp", 32'(bresp_out), 32'(r));
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      @(posedge mclk_in);
      araddr_in <= a;
      arvalid_in <= 1'h1;
      rready_in <= 1'h1;
      do begin
         @(posedge mclk_in);
         if (arready_out) arvalid_in <= 1'h0;
      end while (!rvalid_out);
      rready_in <= 1'h0;
      chk("rdata", rdata_out, e);
      chk("rresp", 32'(rresp_out), 32'(r));
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge mclk_in);
      @(negedge mclk_in);
   endtask
   // Cycles each gate stays low after both loop requests rise
   task automatic meas(input logic [7:0] pe, output int p, output int s);
      wr(apc_pkg::OFS_PE_ONE, pe, ok);
      @(posedge mclk_in);
      loop_primary_pwm_in <= 1'h1;
      loop_secondary_pwm_in <= 1'h1;
      p = 0;
      s = 0;
      repeat (12) begin
         @(negedge mclk_in);
         p += int'(!primary_gate_output_out);
         s += int'(!secondary_gate_output_out);
      end
      @(posedge mclk_in);
      loop_primary_pwm_in <= 1'h0;
      loop_secondary_pwm_in <= 1'h0;
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (3) @(posedge mclk_in);
      resetn_in <= 1'h1;
      tk(1);
      chk("rst out", 32'({desaturation_comparator_output_enable_out, sense_pin_pullup_enable_out,
         analog_to_converter_out, primary_gate_output_out,
         secondary_gate_output_out}), 32'h1c);
      rd(apc_pkg::OFS_REF2_SET, 32'h0, ok);
      rd(apc_pkg::OFS_PE_ONE, 32'h04, ok);
      rd(apc_pkg::OFS_STATUS, 32'h20, ok);
      rd(apc_pkg::OFS_DESATURATION_COMPARATOR_CTL, 32'h1, ok);
      rd(8'h40, 32'h0, apc_pkg::RESP_SLVERR);
      wr(8'h40, 8'hff, apc_pkg::RESP_SLVERR);
      wr(apc_pkg::OFS_REF2_SET, 8'hff, ok);
      rd(apc_pkg::OFS_REF2_SET, 32'hff, ok);
      for (k = 0; k < 4; k++) begin
         wr(apc_pkg::OFS_ROLE, 8'(k), ok);
         tk(2);
         chk("ref pin", 32'(reference_output_pin_connect_out), 32'(k == 1));
      end
      wr(apc_pkg::OFS_PE_ONE, 8'hff, ok);
      rd(apc_pkg::OFS_PE_ONE, 32'hf7, ok);
      wstrb_in <= 4'h0;
      wr(apc_pkg::OFS_PE_ONE, 8'h00, ok);
      wstrb_in <= 4'hf;
      rd(apc_pkg::OFS_PE_ONE, 32'hf7, ok);
      wr(apc_pkg::OFS_PE_ONE, 8'h00, ok);
      tk(2);
      chk("pullup", 32'(sense_pin_pullup_enable_out), 32'h0);
      meas(8'h04, d0, d1);
      chk("both off", d0 + d1, 24);
      meas(8'h84, d0, d1);
      chk("pri on", 32'(d0 < 12), 32'h1);
      chk("sec only off", d1, 32'hc);
      foreach (dt[i]) begin
         wr(apc_pkg::OFS_DEADTIME, {dt[i], dt[i]}, ok);
         meas(8'hc4, d0, d1);
         meas(8'hf4, p1, s1);
         k = (int'(dt[i]) + 1) * apc_pkg::DT_STEP_NS + apc_pkg::CLK_PERIOD_NS - 1;
         k = k / apc_pkg::CLK_PERIOD_NS;
         chk("pri dead", d0 - p1, k);
         chk("sec dead", d1 - s1, k);
      end
      // Quasi-resonant steering wants the desaturation_comparator output off first
      wr(apc_pkg::OFS_DESATURATION_COMPARATOR_CTL, 8'h00, ok);
      wr(apc_pkg::OFS_TMR2_PER, 8'h09, ok);
      wr(apc_pkg::OFS_TMR1_LOW, 8'h03, ok);
      chk("desaturation_comparator oe", 32'(desaturation_comparator_output_enable_out), 32'h0);
      foreach (st[i]) begin
         wr(apc_pkg::OFS_PE_ONE, st[i][31:24], ok);
         ovp_active_in <= st[i][16];
         repeat (12) @(posedge mclk_in);
         clr <= 1'h1;
         @(posedge mclk_in);
         clr <= 1'h0;
         tk(100);
         chk("steer", {pri_on, sec_on},
            {8'h00, st[i][15:8], 8'h00, st[i][7:0]});
      end
      for (k = 0; k < 8; k++) begin
         wr(apc_pkg::OFS_ABE, 8'h80 | 8'(k << 4), ok);
         src <= 7'(1 << k);
         tk(2);
         chk("dbg one", 32'(debug_output_pin_out), 32'(k < 7));
         @(posedge mclk_in);
         src <= ~7'(1 << k);
         tk(2);
         chk("dbg rest", 32'(debug_output_pin_out), 32'h0);
      end
      wr(apc_pkg::OFS_ABE, 8'h01, ok);
      tk(2);
      chk("ana", 32'({debug_output_pin_oe_out, debug_analog_connect_out,
         analog_to_converter_out}), 32'h2);
      wr(apc_pkg::OFS_ABE, 8'h81, ok);
      tk(2);
      chk("ana dig", 32'({debug_output_pin_oe_out, debug_analog_connect_out,
         analog_to_converter_out}), 32'h4);
      print_verdict();
   end
endmodule
`default_nettype wire
